//--- inc/jtm_pkg.sv
// Overview of operation
// RQ1: Panel raises measuring-in-jog-active on measure softkey and holds it while selected.
// RQ2: PLC may supply a different tool number; panel reads it.
// RQ3: Kernel flags probe-one-actuated when probe switches while the axis traverses.
// RQ4: PLC asserts feed disable on probe actuation; kernel then halts axis motion.
// RQ5: PLC holds feed disable while traverse key pressed and measuring active.
// RQ6: PLC issues channel reset; kernel cancels the pending jog traverse.
// RQ7: After key release (handwheel at once) panel requests automatic mode; PLC forwards it.
// RQ8: Kernel reports automatic mode active once the change takes effect.
// RQ9: PLC drops feed disable after automatic mode becomes active.
// RQ10: Panel pulses mode-change-lock request one cycle; PLC asserts and holds lock.
// RQ11: Every panel request lasts exactly one PLC cycle.
// RQ12: PLC latches the one-cycle start-measuring request.
// RQ13: PLC starts the measuring program through cycle start from the latched request.
// RQ14: Program repositions, approaches probe again, retracts; then panel requests jog mode.
// RQ15: On jog request PLC releases mode lock, then selects jog mode.
// RQ16: Kernel answers jog selection with jog-mode-active status.
// RQ17: Panel clears measuring-active on back softkey or leaving the operating area.
// RQ18: Channel reset or back makes PLC drop feed disable, lock and latched requests.
// RQ19: Measuring and calibration trigger on the probe's rising edge.
// RQ20: Calibration runs like measuring but stores trigger-point data, not tool offset.
// RQ21: PLC clears latched start flag after issuing cycle start.
package jtm_pkg;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TOOL_NUM = 8'h08;
    localparam logic [7:0] ADDR_TOOL_OFS = 8'h0C;
    localparam logic [7:0] ADDR_TRIG_PT = 8'h10;
    localparam logic [7:0] ADDR_POSITION = 8'h14;
    localparam logic [7:0] ADDR_DIST = 8'h18;

    localparam int CTRL_MEASURE_BIT = 0;
    localparam int CTRL_BACK_BIT = 1;
    localparam int CTRL_EXIT_BIT = 2;
    localparam int CTRL_CALIB_BIT = 3;

    localparam int ST_MEAS_BIT = 0;
    localparam int ST_PROBE_BIT = 1;
    localparam int ST_AUTO_BIT = 2;
    localparam int ST_JOG_BIT = 3;
    localparam int ST_MOVING_BIT = 4;
    localparam int ST_RUN_BIT = 5;
    localparam int ST_CALIB_BIT = 6;
    localparam int ST_FAIL_BIT = 7;
    localparam int ST_STATE_LSB = 8;

    localparam logic [15:0] DIST_RESET = 16'h0040;
    localparam logic [15:0] APPROACH_MAX_RESET = 16'h1000;
    localparam int PIN_SYNC_STAGES = 3;

    typedef enum logic [3:0] {
        P_IDLE, P_WAIT_PROBE, P_WAIT_RELEASE, P_WAIT_AUTO,
        P_WAIT_LOCK, P_RUN, P_WAIT_JOG
    } panel_state_t;

    typedef enum logic [1:0] {
        K_IDLE, K_REPOS, K_APPROACH, K_RETRACT
    } prog_state_t;

    typedef struct packed {
        logic feed_disable;
        logic chan_reset;
        logic sel_auto;
        logic sel_jog;
        logic mode_lock;
        logic cycle_start;
    } plc_cmd_t;

    typedef struct packed {
        logic meas_jog_active;
        logic req_auto;
        logic req_jog;
        logic req_lock;
        logic req_start;
    } panel_req_t;

    typedef struct packed {
        logic probe_actuated;
        logic auto_active;
        logic jog_active;
        logic axis_moving;
    } kernel_stat_t;

endpackage

//--- verilog/pin_sync.sv
`timescale 1ns/1ns
// Three-stage pin synchroniser; the output follows once stages two and three agree.
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins and result
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level_o <= '0;
        end
        else
        begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < WIDTH; i++)
            begin
                if (s2_q[i] == s3_q[i])
                begin
                    level_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

//--- verilog/jog_tool_measure_handshake.sv
`timescale 1ns/1ns
// Operator panel and control kernel side of tool measuring in jog mode.
module jog_tool_measure_handshake #(
    parameter int POS_W = 32,
    parameter int TOOL_W = 32,
    parameter logic [15:0] APPROACH_MAX = jtm_pkg::APPROACH_MAX_RESET
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Machine pins
    input wire logic probe_i,
    input wire logic trav_key_i,
    input wire logic handwheel_i,
    // PLC user program
    input wire jtm_pkg::plc_cmd_t plc_cmd_i,
    input wire logic [TOOL_W-1:0] plc_tool_num_i,
    output jtm_pkg::panel_req_t panel_req_o,
    output jtm_pkg::kernel_stat_t kernel_stat_o
);
    logic probe_s;
    logic trav_key_s;
    logic handwheel_s;
    logic [2:0] pins_s;

    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({probe_i, trav_key_i, handwheel_i}),
        .level_o(pins_s)
    );

    assign probe_s = pins_s[2];
    assign trav_key_s = pins_s[1];
    assign handwheel_s = pins_s[0];

    // Register bus.
    logic req;
    logic wr_ctrl;
    logic wr_dist;
    logic [31:0] rd_d;
    logic measure_key;
    logic back_key;
    logic exit_key;
    logic calib_q;
    logic [15:0] dist_q;
    logic [TOOL_W-1:0] tool_num_q;
    logic [POS_W-1:0] tool_ofs_q;
    logic [POS_W-1:0] trig_pt_q;
    logic [POS_W-1:0] pos_q;

    assign req = cyc_i && stb_i && !ack_o;
    assign wr_ctrl = req && we_i && sel_i[0] && adr_i == jtm_pkg::ADDR_CTRL;
    assign wr_dist = req && we_i && adr_i == jtm_pkg::ADDR_DIST;
    assign measure_key = wr_ctrl && dat_i[jtm_pkg::CTRL_MEASURE_BIT];
    assign back_key = wr_ctrl && dat_i[jtm_pkg::CTRL_BACK_BIT];
    assign exit_key = wr_ctrl && dat_i[jtm_pkg::CTRL_EXIT_BIT];

    // Kernel and panel state.
    jtm_pkg::panel_state_t pst_q;
    jtm_pkg::prog_state_t kst_q;
    logic meas_active_q;
    logic req_auto_q;
    logic req_jog_q;
    logic req_lock_q;
    logic req_start_q;
    logic probe_act_q;
    logic auto_q;
    logic jog_q;
    logic moving_q;
    logic probe_prev_q;
    logic cancel_q;
    logic prog_end_q;
    logic fail_q;
    logic [15:0] cnt_q;
    logic probe_rise;
    logic jog_move;
    logic prog_move;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= req;
        end
    end

    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (adr_i)
            jtm_pkg::ADDR_CTRL:
            begin
                rd_d[jtm_pkg::CTRL_CALIB_BIT] = calib_q;
            end
            jtm_pkg::ADDR_STATUS:
            begin
                rd_d[jtm_pkg::ST_MEAS_BIT] = meas_active_q;
                rd_d[jtm_pkg::ST_PROBE_BIT] = probe_act_q;
                rd_d[jtm_pkg::ST_AUTO_BIT] = auto_q;
                rd_d[jtm_pkg::ST_JOG_BIT] = jog_q;
                rd_d[jtm_pkg::ST_MOVING_BIT] = moving_q;
                rd_d[jtm_pkg::ST_RUN_BIT] = kst_q != jtm_pkg::K_IDLE;
                rd_d[jtm_pkg::ST_CALIB_BIT] = calib_q;
                rd_d[jtm_pkg::ST_FAIL_BIT] = fail_q;
                rd_d[jtm_pkg::ST_STATE_LSB +: 4] = pst_q;
            end
            jtm_pkg::ADDR_TOOL_NUM: rd_d = 32'(tool_num_q);
            jtm_pkg::ADDR_TOOL_OFS: rd_d = 32'(tool_ofs_q);
            jtm_pkg::ADDR_TRIG_PT: rd_d = 32'(trig_pt_q);
            jtm_pkg::ADDR_POSITION: rd_d = 32'(pos_q);
            jtm_pkg::ADDR_DIST: rd_d[15:0] = dist_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o <= 32'h0000_0000;
        end
        else if (req)
        begin
            dat_o <= we_i ? 32'h0000_0000 : rd_d;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            calib_q <= 1'b0;
            dist_q <= jtm_pkg::DIST_RESET;
        end
        else
        begin
            if (wr_ctrl && pst_q == jtm_pkg::P_IDLE)
            begin
                calib_q <= dat_i[jtm_pkg::CTRL_CALIB_BIT];
            end
            if (wr_dist)
            begin
                if (sel_i[0])
                begin
                    dist_q[7:0] <= dat_i[7:0];
                end
                if (sel_i[1])
                begin
                    dist_q[15:8] <= dat_i[15:8];
                end
            end
        end
    end

    // The panel samples the tool number that the PLC offers.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tool_num_q <= '0;
        end
        else
        begin
            tool_num_q <= plc_tool_num_i; // RQ2
        end
    end

    // Axis motion: feed disable halts everything, a channel reset kills the jog traverse.
    assign probe_rise = probe_s && !probe_prev_q; // RQ19
    assign jog_move = jog_q && trav_key_s && !cancel_q && !plc_cmd_i.feed_disable; // RQ4
    assign prog_move = kst_q != jtm_pkg::K_IDLE && !plc_cmd_i.feed_disable; // RQ4

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            probe_prev_q <= 1'b0;
            cancel_q <= 1'b0;
            moving_q <= 1'b0;
            probe_act_q <= 1'b0;
        end
        else
        begin
            probe_prev_q <= probe_s;
            if (plc_cmd_i.chan_reset && trav_key_s)
            begin
                cancel_q <= 1'b1; // RQ6
            end
            else if (!trav_key_s)
            begin
                cancel_q <= 1'b0;
            end
            moving_q <= jog_move || prog_move;
            if (!probe_s)
            begin
                probe_act_q <= 1'b0;
            end
            else if (probe_rise && moving_q)
            begin
                probe_act_q <= 1'b1; // RQ3
            end
        end
    end

    // Mode selection is ignored while the PLC holds the mode-change lock.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            auto_q <= 1'b0;
            jog_q <= 1'b1;
        end
        else if (!plc_cmd_i.mode_lock && kst_q == jtm_pkg::K_IDLE)
        begin
            if (plc_cmd_i.sel_auto)
            begin
                auto_q <= 1'b1; // RQ8
                jog_q <= 1'b0;
            end
            else if (plc_cmd_i.sel_jog)
            begin
                jog_q <= 1'b1; // RQ16
                auto_q <= 1'b0;
            end
        end
    end

    // Measuring program: reposition, approach until probe edge, retract.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            kst_q <= jtm_pkg::K_IDLE;
            cnt_q <= 16'h0000;
            prog_end_q <= 1'b0;
            fail_q <= 1'b0;
            pos_q <= '0;
            tool_ofs_q <= '0;
            trig_pt_q <= '0;
        end
        else
        begin
            prog_end_q <= 1'b0;
            if (jog_move)
            begin
                pos_q <= pos_q + POS_W'(1);
            end
            if (plc_cmd_i.chan_reset && kst_q != jtm_pkg::K_IDLE)
            begin
                kst_q <= jtm_pkg::K_IDLE;
                prog_end_q <= 1'b1;
                fail_q <= 1'b1;
            end
            else
            begin
                case (kst_q)
                    jtm_pkg::K_IDLE:
                    begin
                        if (plc_cmd_i.cycle_start && auto_q)
                        begin
                            kst_q <= jtm_pkg::K_REPOS; // RQ14
                            cnt_q <= 16'h0000;
                            fail_q <= 1'b0;
                        end
                    end
                    jtm_pkg::K_REPOS:
                    begin
                        if (prog_move)
                        begin
                            pos_q <= pos_q - POS_W'(1);
                            cnt_q <= cnt_q + 16'h0001;
                            if (cnt_q + 16'h0001 >= dist_q)
                            begin
                                kst_q <= jtm_pkg::K_APPROACH; // RQ14
                                cnt_q <= 16'h0000;
                            end
                        end
                    end
                    jtm_pkg::K_APPROACH:
                    begin
                        if (probe_rise)
                        begin
                            if (calib_q)
                            begin
                                trig_pt_q <= pos_q; // RQ20
                            end
                            else
                            begin
                                tool_ofs_q <= pos_q; // RQ20
                            end
                            kst_q <= jtm_pkg::K_RETRACT; // RQ19
                            cnt_q <= 16'h0000;
                        end
                        else if (prog_move)
                        begin
                            pos_q <= pos_q + POS_W'(1);
                            cnt_q <= cnt_q + 16'h0001;
                            if (cnt_q + 16'h0001 >= APPROACH_MAX)
                            begin
                                fail_q <= 1'b1;
                                kst_q <= jtm_pkg::K_RETRACT;
                                cnt_q <= 16'h0000;
                            end
                        end
                    end
                    jtm_pkg::K_RETRACT:
                    begin
                        if (prog_move)
                        begin
                            pos_q <= pos_q - POS_W'(1);
                            cnt_q <= cnt_q + 16'h0001;
                            if (cnt_q + 16'h0001 >= dist_q)
                            begin
                                kst_q <= jtm_pkg::K_IDLE; // RQ14
                                prog_end_q <= 1'b1;
                            end
                        end
                    end
                    default:
                    begin
                        kst_q <= jtm_pkg::K_IDLE;
                    end
                endcase
            end
        end
    end

    // Operator panel sequencer; all requests are single-cycle pulses.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pst_q <= jtm_pkg::P_IDLE;
            meas_active_q <= 1'b0;
            req_auto_q <= 1'b0;
            req_jog_q <= 1'b0;
            req_lock_q <= 1'b0;
            req_start_q <= 1'b0;
        end
        else
        begin
            req_auto_q <= 1'b0; // RQ11
            req_jog_q <= 1'b0; // RQ11
            req_lock_q <= 1'b0; // RQ11
            req_start_q <= 1'b0; // RQ11
            if (back_key || exit_key)
            begin
                pst_q <= jtm_pkg::P_IDLE;
                meas_active_q <= 1'b0; // RQ17
            end
            else
            begin
                case (pst_q)
                    jtm_pkg::P_IDLE:
                    begin
                        if (measure_key)
                        begin
                            meas_active_q <= 1'b1; // RQ1
                            pst_q <= jtm_pkg::P_WAIT_PROBE;
                        end
                    end
                    jtm_pkg::P_WAIT_PROBE:
                    begin
                        if (probe_act_q)
                        begin
                            pst_q <= jtm_pkg::P_WAIT_RELEASE;
                        end
                    end
                    jtm_pkg::P_WAIT_RELEASE:
                    begin
                        if (!trav_key_s || handwheel_s)
                        begin
                            req_auto_q <= 1'b1; // RQ7
                            pst_q <= jtm_pkg::P_WAIT_AUTO;
                        end
                    end
                    jtm_pkg::P_WAIT_AUTO:
                    begin
                        if (auto_q && !plc_cmd_i.feed_disable)
                        begin
                            req_lock_q <= 1'b1; // RQ10
                            pst_q <= jtm_pkg::P_WAIT_LOCK;
                        end
                    end
                    jtm_pkg::P_WAIT_LOCK:
                    begin
                        if (plc_cmd_i.mode_lock)
                        begin
                            req_start_q <= 1'b1;
                            pst_q <= jtm_pkg::P_RUN;
                        end
                    end
                    jtm_pkg::P_RUN:
                    begin
                        if (prog_end_q)
                        begin
                            req_jog_q <= 1'b1; // RQ14
                            pst_q <= jtm_pkg::P_WAIT_JOG;
                        end
                    end
                    jtm_pkg::P_WAIT_JOG:
                    begin
                        if (jog_q)
                        begin
                            pst_q <= jtm_pkg::P_WAIT_PROBE;
                        end
                    end
                    default:
                    begin
                        pst_q <= jtm_pkg::P_IDLE;
                    end
                endcase
            end
        end
    end

    assign panel_req_o = '{
        meas_jog_active: meas_active_q,
        req_auto: req_auto_q,
        req_jog: req_jog_q,
        req_lock: req_lock_q,
        req_start: req_start_q
    };
    assign kernel_stat_o = '{
        probe_actuated: probe_act_q,
        auto_active: auto_q,
        jog_active: jog_q,
        axis_moving: moving_q
    };
endmodule

//--- bench/jtm_props.sv
`timescale 1ns/1ns
module jtm_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    // Sequence link
    input wire jtm_pkg::plc_cmd_t plc_cmd_i,
    input wire jtm_pkg::panel_req_t panel_req_o,
    input wire jtm_pkg::kernel_stat_t kernel_stat_o
);
    logic wr_ctrl;
    assign wr_ctrl = cyc_i && stb_i && we_i && adr_i == jtm_pkg::ADDR_CTRL;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    meas_hold_a: assert property (
        panel_req_o.meas_jog_active && !wr_ctrl |=> panel_req_o.meas_jog_active)
        else $error("measuring flag dropped");
    back_clear_a: assert property (
        wr_ctrl && !ack_o && sel_i[0] && (dat_i[1] || dat_i[2])
        |=> ##[0:1] !panel_req_o.meas_jog_active)
        else $error("measuring flag kept");
    probe_cause_a: assert property (
        $rose(kernel_stat_o.probe_actuated) |-> $past(kernel_stat_o.axis_moving))
        else $error("probe flag without motion");
    feed_halt_a: assert property (
        plc_cmd_i.feed_disable [*2] |-> !kernel_stat_o.axis_moving)
        else $error("axis moved under feed disable");
    auto_req_a: assert property (
        panel_req_o.req_auto |-> panel_req_o.meas_jog_active && kernel_stat_o.jog_active
            && !kernel_stat_o.axis_moving)
        else $error("automatic request out of order");
    auto_ack_a: assert property (
        plc_cmd_i.sel_auto && !plc_cmd_i.sel_jog && !plc_cmd_i.mode_lock
            && !kernel_stat_o.auto_active |=> kernel_stat_o.auto_active)
        else $error("automatic mode not reported");
    lock_pulse_a: assert property (
        panel_req_o.req_lock |-> (kernel_stat_o.auto_active && !plc_cmd_i.feed_disable)
            ##1 !panel_req_o.req_lock)
        else $error("lock request wrong");
    start_pulse_a: assert property (
        panel_req_o.req_start |-> plc_cmd_i.mode_lock ##1 !panel_req_o.req_start)
        else $error("start request wrong");
    jog_ack_a: assert property (
        plc_cmd_i.sel_jog && !plc_cmd_i.sel_auto && !plc_cmd_i.mode_lock
            && !kernel_stat_o.jog_active |=> kernel_stat_o.jog_active)
        else $error("jog mode not reported");
endmodule

bind jog_tool_measure_handshake jtm_props jtm_props_i (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .plc_cmd_i, .panel_req_o, .kernel_stat_o);

//--- bench/plc_model.sv
`timescale 1ns/1ns
// PLC user program; slow_i delays cycle start.
module plc_model #(
    // Arbitrary tool number.
    parameter logic [31:0] TOOL_NUM = 32'h0000_0007
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench controls
    input wire logic abort_i,
    input wire logic slow_i,
    input wire logic trav_key_i,
    // Sequence link
    input wire jtm_pkg::panel_req_t req_i,
    input wire jtm_pkg::kernel_stat_t stat_i,
    output jtm_pkg::plc_cmd_t cmd_o,
    output logic [31:0] tool_num_o
);
    logic start_q;
    logic jog_q;
    logic sent_q;
    logic [3:0] wait_q;
    assign tool_num_o = TOOL_NUM;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd_o <= '0;
            start_q <= 1'b0;
            jog_q <= 1'b0;
            sent_q <= 1'b0;
            wait_q <= 4'h0;
        end
        else
        begin
            cmd_o.chan_reset <= abort_i;
            cmd_o.cycle_start <= 1'b0;
            jog_q <= req_i.req_jog;
            wait_q <= start_q ? wait_q + 4'h1 : 4'h0;
            if (stat_i.probe_actuated && stat_i.jog_active)
                cmd_o.feed_disable <= 1'b1;
            if (cmd_o.feed_disable && !sent_q)
            begin
                cmd_o.chan_reset <= 1'b1;
                sent_q <= 1'b1;
            end
            if (stat_i.auto_active && !(trav_key_i && req_i.meas_jog_active))
            begin
                cmd_o.feed_disable <= 1'b0;
                sent_q <= 1'b0;
            end
            if (req_i.req_auto)
                cmd_o.sel_auto <= 1'b1;
            else if (stat_i.auto_active)
                cmd_o.sel_auto <= 1'b0;
            if (req_i.req_lock)
                cmd_o.mode_lock <= 1'b1;
            if (req_i.req_start)
                start_q <= 1'b1;
            if (start_q && stat_i.auto_active && (!slow_i || wait_q == 4'h8))
            begin
                cmd_o.cycle_start <= 1'b1;
                start_q <= 1'b0;
            end
            if (req_i.req_jog)
                cmd_o.mode_lock <= 1'b0;
            if (jog_q)
                cmd_o.sel_jog <= 1'b1;
            else if (stat_i.jog_active)
                cmd_o.sel_jog <= 1'b0;
            if (abort_i || !req_i.meas_jog_active)
            begin
                cmd_o.feed_disable <= 1'b0;
                cmd_o.mode_lock <= 1'b0;
                start_q <= 1'b0;
            end
        end
    end
endmodule

//--- bench/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o;
    logic probe_i = 1'b0;
    logic trav_key_i = 1'b0;
    logic handwheel_i = 1'b0;
    logic abort_q = 1'b0;
    logic slow_q = 1'b0;
    jtm_pkg::plc_cmd_t plc_cmd_i;
    logic [31:0] plc_tool_num_i;
    jtm_pkg::panel_req_t panel_req_o;
    jtm_pkg::kernel_stat_t kernel_stat_o;
    logic [5:0] ev;
    logic [31:0] q;
    logic [31:0] ofs;
    int err_count = 0;
    int n_tests = 0;

    always #5 clk_i = ~clk_i;
    assign ev = {panel_req_o.meas_jog_active, plc_cmd_i.cycle_start, kernel_stat_o.jog_active,
        kernel_stat_o.auto_active, kernel_stat_o.probe_actuated, kernel_stat_o.axis_moving};

    jog_tool_measure_handshake #(.APPROACH_MAX(16'h0010)) jog_tool_measure_handshake_i (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .probe_i, .trav_key_i, .handwheel_i, .plc_cmd_i, .plc_tool_num_i, .panel_req_o,
        .kernel_stat_o);
    plc_model plc_model_i (.clk_i, .rst_i, .abort_i(abort_q), .slow_i(slow_q), .trav_key_i,
        .req_i(panel_req_o), .stat_i(kernel_stat_o), .cmd_o(plc_cmd_i),
        .tool_num_o(plc_tool_num_i));

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 100);
        check("bus answer", {31'h0, ack_o}, 32'h1);
        if (ack_o !== 1'b1)
            test_done();
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(what, q, exp);
    endtask
    task automatic wait_ev(input int i, input logic v);
        int n;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ev[i] !== v && n < 3000);
        if (ev[i] !== v)
        begin
            err_count++;
            $display("unexpected event %0d: expected %b seen %b", i, v, ev[i]);
            test_done();
        end
    endtask

    // Jog into the probe, then run; touch 0 aborts.
    task automatic seq(input logic hw, input logic touch);
        handwheel_i <= hw;
        trav_key_i <= 1'b1;
        wait_ev(0, 1'b1);
        probe_i <= 1'b1;
        wait_ev(1, 1'b1);
        wait_ev(0, 1'b0);
        trav_key_i <= hw;
        wait_ev(2, 1'b1);
        trav_key_i <= 1'b0;
        probe_i <= 1'b0;
        wait_ev(4, 1'b1);
        repeat (10) @(posedge clk_i);
        probe_i <= touch;
        abort_q <= !touch;
        @(posedge clk_i);
        abort_q <= 1'b0;
        repeat (6) @(posedge clk_i);
        probe_i <= 1'b0;
        wait_ev(3, 1'b1);
    endtask

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("status", jtm_pkg::ADDR_STATUS, 32'h0000_0008);
        rd("distance", jtm_pkg::ADDR_DIST, 32'h0000_0040);
        wb(1'b1, jtm_pkg::ADDR_DIST, 32'h0000_0005);
        rd("distance", jtm_pkg::ADDR_DIST, 32'h0000_0005);
        wb(1'b1, jtm_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        rd("status", jtm_pkg::ADDR_STATUS, 32'h0000_0008);
        rd("tool", jtm_pkg::ADDR_TOOL_NUM, 32'h0000_0007);
        rd("unmapped", 8'h1C, 32'h0000_0000);
        $display("register test done");
        wb(1'b1, jtm_pkg::ADDR_CTRL, 32'h0000_0001);
        rd("status", jtm_pkg::ADDR_STATUS, 32'h0000_0109);
        seq(1'b0, 1'b1);
        rd("status", jtm_pkg::ADDR_STATUS, 32'h0000_0109);
        rd("trigger point", jtm_pkg::ADDR_TRIG_PT, 32'h0000_0000);
        wb(1'b0, jtm_pkg::ADDR_TOOL_OFS, 32'h0);
        ofs = q;
        wb(1'b1, jtm_pkg::ADDR_CTRL, 32'h0000_0002);
        rd("status", jtm_pkg::ADDR_STATUS, 32'h0000_0008);
        $display("measure test done");
        slow_q <= 1'b1;
        wb(1'b1, jtm_pkg::ADDR_CTRL, 32'h0000_0009);
        rd("status", jtm_pkg::ADDR_STATUS, 32'h0000_0149);
        seq(1'b1, 1'b1);
        rd("offset", jtm_pkg::ADDR_TOOL_OFS, ofs);
        wb(1'b1, jtm_pkg::ADDR_CTRL, 32'h0000_0004);
        wb(1'b0, jtm_pkg::ADDR_STATUS, 32'h0);
        check("measuring flag", {31'h0, q[0]}, 32'h0);
        wb(1'b1, jtm_pkg::ADDR_CTRL, 32'h0000_0000);
        $display("calibration test done");
        slow_q <= 1'b0;
        wb(1'b1, jtm_pkg::ADDR_CTRL, 32'h0000_0001);
        seq(1'b0, 1'b0);
        rd("status", jtm_pkg::ADDR_STATUS, 32'h0000_0189);
        wb(1'b1, jtm_pkg::ADDR_CTRL, 32'h0000_0002);
        $display("abort test done");
        test_done();
    end
endmodule
